// *** bench/igf_ctrl_checker.sv ***
// Port checker for the gate command controller
`timescale 1ns/1ps
module igf_ctrl_checker
    import igf_pkg::*;
#(
    parameter longint RESTART_CYC = RESTART_CYC_L
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [2:0] highSideCommand,
    input wire logic [2:0] lowSideCommand,
    input wire logic highSideShutdownInput,
    input wire logic faultLineIn,
    input wire logic faultLineOut,
    input wire logic faultLineOe,
    input wire logic currentLimitOutput
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    wire logic [2:0] hc = highSideCommand;
    wire logic [2:0] lc = lowSideCommand;
    logic [1:0] flt_q;
    logic [31:0] quiet_q;
    logic [15:0] oeLen_q;
    function automatic logic [15:0] inc(input logic [15:0] v);
        return v + {15'h0, ~&v};
    endfunction
    // Quiet time counts from a device fault pulling the pin, not our own pull
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flt_q <= 2'h3;
            quiet_q <= '1;
            oeLen_q <= 16'h0;
        end else begin
            flt_q <= {flt_q[0], faultLineIn};
            quiet_q <= (flt_q == 2'h2 && !faultLineOe) ? '0 : quiet_q + {31'h0, ~&quiet_q};
            oeLen_q <= faultLineOe ? inc(oeLen_q) : 16'h0;
        end
    end
    for (genvar i = 0; i < 3; i++) begin : g_ph
        logic [15:0] offH_q;
        logic [15:0] offL_q;
        logic [15:0] rise_q;
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                offH_q <= '1;
                offL_q <= '1;
                rise_q <= '1;
            end else begin
                offH_q <= hc[i] ? 16'h0 : inc(offH_q);
                offL_q <= lc[i] ? 16'h0 : inc(offL_q);
                rise_q <= (hc[i] && offH_q != 16'h0) ? 16'h1 : inc(rise_q);
            end
        end
        a_dead_high: assert property ($rose(hc[i]) |-> offL_q >= DEAD_CYC)
            else $error("high command too soon after low");
        a_dead_low: assert property ($rose(lc[i]) |-> offH_q >= DEAD_CYC)
            else $error("low command too soon after high");
        a_carrier_gap: assert property ($rose(hc[i]) |-> rise_q >= MIN_PERIOD_CYC)
            else $error("carrier period too short");
        a_pulse_min: assert property ($fell(hc[i]) && &flt_q |-> rise_q >= MIN_PULSE_CYC)
            else $error("high pulse too short");
    end
    a_fault_stop: assert property ($fell(faultLineIn) |-> ##[1:4] {hc, lc} == 6'h0)
        else $error("commands not removed after fault");
    a_restart_wait: assert property ($rose(|{hc, lc}) |-> quiet_q >= RESTART_CYC)
        else $error("restart too soon after fault");
    a_shut_len: assert property ($fell(faultLineOe) |-> oeLen_q >= SHUT_CYC)
        else $error("shutdown pulse too short");
    a_pull_only: assert property (faultLineOe |-> !faultLineOut)
        else $error("fault line driven high");
    a_limit_shut: assert property (currentLimitOutput |-> ##[1:4] highSideShutdownInput)
        else $error("high side shutdown not raised");
endmodule // igf_ctrl_checker

bind igf_ctrl igf_ctrl_checker #(.RESTART_CYC(RESTART_CYC)) u_igf_ctrl_checker (
    .clk(clk), .nrst(nrst), .highSideCommand(highSideCommand),
    .lowSideCommand(lowSideCommand), .highSideShutdownInput(highSideShutdownInput),
    .faultLineIn(faultLineIn), .faultLineOut(faultLineOut), .faultLineOe(faultLineOe),
    .currentLimitOutput(currentLimitOutput)
);

// *** bench/igf_ctrl_tb.sv ***
// Testbench for the gate command controller
`timescale 1ns/1ps
module igf_ctrl_tb
    import igf_pkg::*;
;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] busAddr = 4'h0;
    logic [15:0] busWdata = 16'h0;
    logic busWr = 1'b0;
    logic busRd = 1'b0;
    logic limitFlag = 1'b0;
    logic tripFlag = 1'b0;
    logic [15:0] regs [16];
    wire logic [15:0] busRdata;
    wire logic [2:0] hCmd, lCmd, hGate, lGate;
    wire logic shut, oe, pullOut, limitOut, devPull;
    wire logic faultLine = !((oe && !pullOut) || devPull);
    int err_total = 0;
    int total_checks = 0;
    int seed = 15569;
    igf_ctrl #(.RESTART_CYC(2000)) u_igf_ctrl (
        .clk(clk), .nrst(nrst), .busAddr(busAddr), .busWdata(busWdata),
        .busWr(busWr), .busRd(busRd), .busRdata(busRdata),
        .highSideCommand(hCmd), .lowSideCommand(lCmd),
        .highSideShutdownInput(shut), .faultLineIn(faultLine),
        .faultLineOut(pullOut), .faultLineOe(oe), .currentLimitOutput(limitOut)
    );
    igf_dev u_igf_dev (
        .clk(clk), .hCmd(hCmd), .lCmd(lCmd), .shutIn(shut), .faultPin(faultLine),
        .limitFlag(limitFlag), .tripFlag(tripFlag), .limitOut(limitOut),
        .faultPull(devPull), .hGate(hGate), .lGate(lGate)
    );
    always #12.5 clk = ~clk;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        regs[a] = d;
        busAddr <= a;
        busWdata <= d;
        busWr <= 1'b1;
        @(posedge clk);
        busWr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
        @(posedge clk);
        busAddr <= a;
        busRd <= 1'b1;
        @(posedge clk);
        busRd <= 1'b0;
        #1 chk(busRdata & m, e);
        @(posedge clk);
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Whole run needs about 26500 cycles
    initial begin
        repeat (60000) @(posedge clk);
        err_total++;
        complete_run;
    end
    initial begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        rd(ADDR_PERIOD, 16'hFFFF, PERIOD_RST);
        rd(4'hF, 16'hFFFF, 16'h0);
        rd(ADDR_STATUS, 16'h003F, 16'h0);
        wr(ADDR_PERIOD, 16'h0064);
        rd(ADDR_PERIOD, 16'hFFFF, 16'(MIN_PERIOD_CYC));
        wr(ADDR_PERIOD, 16'h0BB8);
        for (int i = 1; i < 4; i++) wr(4'(i), 16'(300 + {$random(seed)} % 2400));
        for (int i = 1; i < 5; i++) rd(4'(i), 16'hFFFF, regs[i]);
        wr(ADDR_CTRL, 16'h0003);
        repeat (9000) @(posedge clk);
        rd(ADDR_STATUS, 16'h0030, {10'h0, IGF_RUN, 4'h0});
        limitFlag <= 1'b1;
        repeat (300) @(posedge clk);
        rd(ADDR_STATUS, 16'h0004, 16'h0004);
        chk({13'h0, hGate}, 16'h0);
        limitFlag <= 1'b0;
        repeat (3000) @(posedge clk);
        tripFlag <= 1'b1;
        repeat (100) @(posedge clk);
        tripFlag <= 1'b0;
        chk({10'h0, hCmd, lCmd}, 16'h0);
        rd(ADDR_STATUS, 16'h0033, {10'h0, IGF_WAIT, 4'h3});
        wr(ADDR_CTRL, 16'h0003);
        rd(ADDR_STATUS, 16'h0030, {10'h0, IGF_WAIT, 4'h0});
        repeat (4000) @(posedge clk);
        rd(ADDR_STATUS, 16'h0032, {10'h0, IGF_IDLE, 4'h0});
        wr(ADDR_CTRL, 16'h0004);
        rd(ADDR_STATUS, 16'h0001, 16'h0);
        wr(ADDR_CTRL, 16'h0001);
        repeat (6000) @(posedge clk);
        wr(ADDR_CTRL, 16'h000B);
        repeat (20) @(posedge clk);
        chk({15'h0, shut}, 16'h0001);
        rd(ADDR_STATUS, 16'h0008, 16'h0008);
        chk({13'h0, lGate}, 16'h0);
        repeat (4000) @(posedge clk);
        rd(ADDR_STATUS, 16'h0008, 16'h0);
        rd(ADDR_STATUS, 16'h0031, {10'h0, IGF_RUN, 4'h0});
        complete_run;
    end
endmodule // igf_ctrl_tb

// *** bench/igf_dev.sv ***
// Behavioural model of the gate driver device
`timescale 1ns/1ps
module igf_dev #(
    parameter int BLANK = 80,
    parameter int HOLD = 1000,
    parameter int SDF = 132
) (
    input wire logic clk,
    input wire logic [2:0] hCmd,
    input wire logic [2:0] lCmd,
    input wire logic shutIn,
    input wire logic faultPin,
    input wire logic limitFlag,
    input wire logic tripFlag,
    output logic limitOut,
    output logic faultPull,
    output logic [2:0] hGate,
    output logic [2:0] lGate
);
    int blankCnt = 0;
    int holdCnt = 0;
    int sdCnt = 0;
    logic [2:0] hPrev = 3'h0;
    assign limitOut = limitFlag | tripFlag;
    assign faultPull = holdCnt > 0;
    assign lGate = lCmd & {3{faultPin}};
    initial hGate = 3'h0;
    always @(posedge clk) begin
        blankCnt <= tripFlag ? blankCnt + 1 : 0;
        holdCnt <= (blankCnt >= BLANK) ? HOLD : (holdCnt > 0 ? holdCnt - 1 : 0);
        sdCnt <= shutIn ? sdCnt + 1 : 0;
        hPrev <= hCmd;
        for (int i = 0; i < 3; i++) begin
            if (sdCnt >= SDF || !hCmd[i]) hGate[i] <= 1'b0;
            else if (!hPrev[i]) hGate[i] <= 1'b1;
        end
    end
endmodule // igf_dev

// *** rtl/igf_ctrl.sv ***
// Controller driving a three-phase inverter gate driver
// Operation
// - Leave at least 1.5 us dead time between complementary transistors.
// - Keep PWM carrier at or below 20 kHz.
// - Every high or low command pulse lasts at least 0.5 us; fault going low or leaving IGF_RUN cuts pulses short.
// - Always actively drive the phase command lines.
// - Controller shutdown pulses on fault line last at least 6 us.
// - Remove all phase commands within 15 us of fault going low.
// - Wait at least 2 seconds after a fault before restarting.
// - Inverted fault line may feed high-side shutdown input.
`timescale 1ns/1ps
module igf_ctrl
    import igf_pkg::*;
#(
    parameter longint RESTART_CYC = RESTART_CYC_L,
    parameter int CW = 16
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [3:0] busAddr,
    input wire logic [15:0] busWdata,
    input wire logic busWr,
    input wire logic busRd,
    output logic [15:0] busRdata,
    output logic [2:0] highSideCommand,
    output logic [2:0] lowSideCommand,
    output logic highSideShutdownInput,
    input wire logic faultLineIn,
    output logic faultLineOut,
    output logic faultLineOe,
    input wire logic currentLimitOutput
);
    typedef struct packed {
        igf_state_e st;
        logic shutOnFault;
        logic [CW-1:0] period;
        logic [CW-1:0] duty0;
        logic [CW-1:0] duty1;
        logic [CW-1:0] duty2;
        logic [CW-1:0] count;
        logic [35:0] timer;
        logic shutReq;
        logic [15:0] shutCnt;
        logic pullLow;
        logic [1:0] pullTail;
        logic faultSeen;
        logic [15:0] hold;
        logic [15:0] rdata;
        igf_gate_s gate;
        logic hsd;
        logic phaseOn;
    } igf_top_s;

    igf_top_s s_q, s_d;
    logic [1:0] rstSync;
    logic rstN;
    logic [1:0] faultSync;
    logic [1:0] limSync;
    logic faultLow;
    logic limHigh;
    logic runEn;
    logic faultExt;
    igf_bus_s bus;
    igf_gate_s pwm;

    initial begin
        if (CW != 16 || RESTART_CYC < 1 || RESTART_CYC > 64'h0000_000F_FFFF_FFFF) begin
            $error("Bad controller parameters");
        end
    end

    // ----------------------------------------
    // Reset and pin synchronisers
    // ----------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rstSync <= 2'b00;
        end else begin
            rstSync <= {rstSync[0], 1'b1};
        end
    end
    assign rstN = rstSync[1];

    // Pins are asynchronous to our clock
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            faultSync <= 2'b11;
            limSync <= 2'b00;
        end else begin
            faultSync <= {faultSync[0], faultLineIn};
            limSync <= {limSync[0], currentLimitOutput};
        end
    end
    assign faultLow = !faultSync[1];
    assign limHigh = limSync[1];
    assign bus = '{addr: busAddr, wdata: busWdata, wr: busWr, rd: busRd};
    assign runEn = (s_q.st == IGF_RUN);
    // Own pull is not a device fault
    assign faultExt = faultLow && !s_q.pullLow && !(|s_q.pullTail);

    // ----------------------------------------
    // Phase generators
    // ----------------------------------------
    igf_phase #(.CW(CW)) uPhU (.clk(clk), .rstN(rstN), .enable(s_q.phaseOn), .count(s_q.count),
        .duty(s_q.duty0), .highCmd(pwm.high[0]), .lowCmd(pwm.low[0]));
    igf_phase #(.CW(CW)) uPhV (.clk(clk), .rstN(rstN), .enable(s_q.phaseOn), .count(s_q.count),
        .duty(s_q.duty1), .highCmd(pwm.high[1]), .lowCmd(pwm.low[1]));
    igf_phase #(.CW(CW)) uPhW (.clk(clk), .rstN(rstN), .enable(s_q.phaseOn), .count(s_q.count),
        .duty(s_q.duty2), .highCmd(pwm.high[2]), .lowCmd(pwm.low[2]));

    // ----------------------------------------
    // Control
    // ----------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.rdata = 16'h0000;
        if (s_q.count + CW'(1) >= s_q.period) begin
            s_d.count = '0;
        end else begin
            s_d.count = s_q.count + CW'(1);
        end
        // Restart phases at the normal rise point of a period
        if (faultLow || s_q.st != IGF_RUN) begin
            s_d.phaseOn = 1'b0;
        end else if (s_q.count == CW'(1)) begin
            s_d.phaseOn = 1'b1;
        end
        if (bus.wr) begin
            if (bus.addr == ADDR_CTRL) begin
                if (bus.wdata[CTRL_RUN_BIT] && s_q.st == IGF_IDLE) begin
                    s_d.st = IGF_RUN;
                end else if (!bus.wdata[CTRL_RUN_BIT] && s_q.st == IGF_RUN) begin
                    s_d.st = IGF_IDLE;
                end
                s_d.shutOnFault = bus.wdata[CTRL_SHUT_BIT];
                if (bus.wdata[CTRL_CLR_BIT]) begin
                    s_d.faultSeen = 1'b0;
                end
                if (bus.wdata[CTRL_SHUT_BIT + 2]) begin
                    s_d.shutReq = 1'b1;
                end
            end else if (bus.addr == ADDR_DUTY_U) begin
                s_d.duty0 = bus.wdata[CW-1:0];
            end else if (bus.addr == ADDR_DUTY_V) begin
                s_d.duty1 = bus.wdata[CW-1:0];
            end else if (bus.addr == ADDR_DUTY_W) begin
                s_d.duty2 = bus.wdata[CW-1:0];
            end else if (bus.addr == ADDR_PERIOD) begin
                if (bus.wdata < 16'(MIN_PERIOD_CYC)) begin
                    s_d.period = CW'(MIN_PERIOD_CYC);
                end else begin
                    s_d.period = bus.wdata[CW-1:0];
                end
            end
        end
        if (bus.rd) begin
            if (bus.addr == ADDR_CTRL) begin
                s_d.rdata = {14'h0000, s_q.shutOnFault, runEn};
            end else if (bus.addr == ADDR_DUTY_U) begin
                s_d.rdata = s_q.duty0[15:0];
            end else if (bus.addr == ADDR_DUTY_V) begin
                s_d.rdata = s_q.duty1[15:0];
            end else if (bus.addr == ADDR_DUTY_W) begin
                s_d.rdata = s_q.duty2[15:0];
            end else if (bus.addr == ADDR_PERIOD) begin
                s_d.rdata = s_q.period[15:0];
            end else if (bus.addr == ADDR_STATUS) begin
                s_d.rdata = {10'h000, s_q.st, s_q.pullLow, limHigh, faultLow, s_q.faultSeen};
            end
        end
        if (s_q.shutReq && !s_q.pullLow) begin
            s_d.pullLow = 1'b1;
            s_d.shutReq = 1'b0;
            s_d.shutCnt = '0;
        end else if (s_q.pullLow) begin
            if (s_q.shutCnt >= 16'(SHUT_CYC - 1)) begin
                s_d.pullLow = 1'b0;
            end else begin
                s_d.shutCnt = s_q.shutCnt + 16'h0001;
            end
        end
        // Pin reads low two more cycles after own release
        s_d.pullTail = {s_q.pullTail[0], s_q.pullLow};
        if (faultExt) begin
            s_d.faultSeen = 1'b1;
            s_d.st = IGF_WAIT;
            s_d.timer = '0;
        end else if (s_q.st == IGF_WAIT) begin
            if (64'(s_q.timer) >= RESTART_CYC - 1) begin
                s_d.st = IGF_IDLE;
            end else begin
                s_d.timer = s_q.timer + 36'h1;
            end
        end
        // Phase pulses already at least minimum pulse width
        s_d.gate = pwm;
        if (faultLow || s_q.st != IGF_RUN) begin
            s_d.gate = '0;
        end
        // Inverted fault or limit to shutdown
        s_d.hsd = limHigh || (s_q.shutOnFault && faultLow);
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            s_q <= '0;
            s_q.period <= CW'(PERIOD_RST);
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Always driven lines
    assign highSideCommand = s_q.gate.high;
    assign lowSideCommand = s_q.gate.low;
    assign highSideShutdownInput = s_q.hsd;
    assign faultLineOut = 1'b0;
    assign faultLineOe = s_q.pullLow;
    assign busRdata = s_q.rdata;
endmodule // igf_ctrl

// *** rtl/igf_phase.sv ***
// One phase: PWM compare with dead time and minimum pulse width
`timescale 1ns/1ps
module igf_phase
    import igf_pkg::*;
#(
    parameter int CW = 16
) (
    input wire logic clk,
    input wire logic rstN,
    input wire logic enable,
    input wire logic [CW-1:0] count,
    input wire logic [CW-1:0] duty,
    output logic highCmd,
    output logic lowCmd
);
    typedef struct packed {
        logic want;
        logic high;
        logic low;
        logic [7:0] dead;
    } igf_ph_s;
    igf_ph_s s_q, s_d;

    initial begin
        if (DEAD_CYC > 255 || MIN_PULSE_CYC > DEAD_CYC) $error("Dead count too wide");
    end

    always_comb begin
        s_d = s_q;
        s_d.want = enable && (count < duty);
        if (!enable) begin
            s_d.high = 1'b0;
            s_d.low = 1'b0;
            // Full dead gap again after any forced stop
            s_d.dead = 8'h00;
        end else if ((s_q.high && !s_q.want) || (s_q.low && s_q.want)) begin
            if (s_q.dead < 8'(MIN_PULSE_CYC)) begin
                s_d.dead = s_q.dead + 8'h01;
            end else begin
                s_d.high = 1'b0;
                s_d.low = 1'b0;
                s_d.dead = 8'h00;
            end
        end else if (!s_q.high && !s_q.low) begin
            if (s_q.dead < 8'(DEAD_CYC)) begin
                s_d.dead = s_q.dead + 8'h01;
            end else begin
                s_d.high = s_q.want;
                s_d.low = !s_q.want;
                s_d.dead = 8'h00;
            end
        end else if (s_q.dead < 8'(MIN_PULSE_CYC)) begin
            s_d.dead = s_q.dead + 8'h01;
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign highCmd = s_q.high;
    assign lowCmd = s_q.low;
endmodule // igf_phase

// *** rtl/igf_pkg.sv ***
// Package for the inverter gate command controller
package igf_pkg;
    // ----------------------------------------
    // Clock and timing
    // ----------------------------------------
    localparam int CLK_HZ = 40_000_000;
    localparam int DEAD_NS = 1500;
    localparam int DEAD_CYC = (DEAD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int MIN_PULSE_NS = 500;
    localparam int MIN_PULSE_CYC = (MIN_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int MIN_PERIOD_NS = 50_000;
    localparam int MIN_PERIOD_CYC = (MIN_PERIOD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int SHUT_NS = 6000;
    localparam int SHUT_CYC = (SHUT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int HOLD_NS = 15_000;
    localparam int HOLD_CYC = (HOLD_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam int RESTART_S = 2;
    localparam longint RESTART_CYC_L = longint'(RESTART_S) * CLK_HZ;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_DUTY_U = 4'h1;
    localparam logic [3:0] ADDR_DUTY_V = 4'h2;
    localparam logic [3:0] ADDR_DUTY_W = 4'h3;
    localparam logic [3:0] ADDR_PERIOD = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h5;
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_SHUT_BIT = 1;
    localparam int CTRL_CLR_BIT = 2;
    localparam logic [15:0] PERIOD_RST = 16'h0800;
    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {
        IGF_IDLE = 2'b00,
        IGF_RUN = 2'b01,
        IGF_WAIT = 2'b11
    } igf_state_e;
    typedef struct packed {
        logic [2:0] high;
        logic [2:0] low;
    } igf_gate_s;
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } igf_bus_s;
endpackage
